/* File: hw/awc_adc_core.sv */
// add-with-carry execution unit with operand addressing and wishbone registers
// Functional notes
// - flags: V7, H4, I3, N2, Z1, C0
// - two-byte value: high byte at lower address
// - direct page: high address byte zero
// - branch target: next address plus signed byte
// - long absolute address: high byte first
// - wide displacement high first; short one byte
// - wide index displacement adds modulo 65536
// - post-increment index mode not accepted here
// - stack modes add displacement to stack pointer
// - accumulator gets accumulator plus operand plus carry
// - overflow on signed overflow of sum
// - half carry from bit three
// - negative is bit seven; zero when result zero
// - carry from most significant bit
// - opcodes a9 b9 c9: 2,3,4 cycles
// - opcodes d9 e9 f9: 4,3,2 cycles
// - prefixed d9 e9: 5,4 cycles
//
// Decided for this implementation: register access over Wishbone and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "awc_map.svh"
module awc_adc_core import awc_pkg::*; #(
    parameter int MEM_AW = 8
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             busy_o,
    output logic             done_o
);
    awc_state_e  st;
    awc_state_e  next_st;
    awc_mode_e   mode;
    awc_mode_e   dec_mode;
    awc_flags_s  flags;
    awc_alu_s    alu_out;
    logic [7:0]  acc;
    logic [15:0] index_pair;
    logic [15:0] stack_ptr;
    logic [15:0] pc;
    logic [15:0] last_ea;
    logic [15:0] branch_tgt;
    logic [7:0]  wide_high;
    logic        prefixed;
    logic [3:0]  cyc_cnt;
    logic [3:0]  last_cycles;
    logic        illegal;
    logic        done_sticky;
    logic        mem_pend;
    logic [7:0]  mem_q;

    function automatic logic [15:0] lane16(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] sel);
        lane16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
    endfunction

    // bus decode
    wire        wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire        mem_sel  = wb_adr_i[`AWC_MEM_BIT];
    wire        reg_wr   = wb_req & ~mem_sel & wb_we_i;
    wire        sw_wr    = reg_wr & ~busy_o;
    wire        mem_go   = wb_req & mem_sel & ~busy_o & ~mem_pend;
    wire        start    = reg_wr & (wb_adr_i == `AWC_ADR_CTRL) & wb_sel_i[0]
                           & wb_dat_i[`AWC_CTRL_START] & ~busy_o;
    wire        wr_acc   = sw_wr & (wb_adr_i == `AWC_ADR_ACC) & wb_sel_i[0];
    wire        wr_flags = sw_wr & (wb_adr_i == `AWC_ADR_FLAGS) & wb_sel_i[0];
    wire        wr_index = sw_wr & (wb_adr_i == `AWC_ADR_INDEX);
    wire        wr_stack = sw_wr & (wb_adr_i == `AWC_ADR_STACK);
    wire        wr_pc    = sw_wr & (wb_adr_i == `AWC_ADR_PC);
    wire        wr_brnch = sw_wr & (wb_adr_i == `AWC_ADR_BRANCH) & wb_sel_i[0];

    // opcode decode
    wire        is_pre   = ~prefixed & (mem_q == `AWC_OP_PREFIX);
    // only the add-with-carry opcodes are accepted
    wire        dec_ok   = prefixed
                           ? (mem_q == `AWC_OP_STK_LONG) | (mem_q == `AWC_OP_STK_SHRT)
                           : (mem_q == `AWC_OP_LIT) | (mem_q == `AWC_OP_DIRECT)
                             | (mem_q == `AWC_OP_LONG_ABS) | (mem_q == `AWC_OP_IDX_LONG)
                             | (mem_q == `AWC_OP_IDX_SHRT) | (mem_q == `AWC_OP_IDX_PLN);
    assign dec_mode = prefixed ? ((mem_q == `AWC_OP_STK_LONG) ? STACK_LONG_DISP_MODE
                                                              : STACK_SHORT_DISP_MODE)
                    : (mem_q == `AWC_OP_LIT)      ? LITERAL_OPERAND_MODE
                    : (mem_q == `AWC_OP_DIRECT)   ? DIRECT_PAGE_MODE
                    : (mem_q == `AWC_OP_LONG_ABS) ? LONG_ABSOLUTE_MODE
                    : (mem_q == `AWC_OP_IDX_LONG) ? INDEX_LONG_DISP_MODE
                    : (mem_q == `AWC_OP_IDX_SHRT) ? INDEX_SHORT_DISP_MODE
                    : INDEX_PLAIN_MODE;
    wire        dec_short = (dec_mode == LITERAL_OPERAND_MODE) | (dec_mode == INDEX_PLAIN_MODE);
    wire        two_arg   = (mode == LONG_ABSOLUTE_MODE) | (mode == INDEX_LONG_DISP_MODE)
                            | (mode == STACK_LONG_DISP_MODE);

    // effective address
    // first stream byte is the high half
    wire [15:0] arg_word  = {wide_high, mem_q};
    wire [15:0] arg_short = {8'h00, mem_q};
    logic [15:0] ea_calc;
    // index pair or stack pointer plus displacement, modulo 65536; direct and long absolute use the bare address
    assign ea_calc = (mode == DIRECT_PAGE_MODE)      ? arg_short
                   : (mode == LONG_ABSOLUTE_MODE)    ? arg_word
                   : (mode == INDEX_LONG_DISP_MODE)  ? index_pair + arg_word
                   : (mode == INDEX_SHORT_DISP_MODE) ? index_pair + arg_short
                   : (mode == STACK_LONG_DISP_MODE)  ? stack_ptr + arg_word
                   : (mode == STACK_SHORT_DISP_MODE) ? stack_ptr + arg_short
                   : index_pair;
    wire        plain_go  = (st == ST_DEC) & ~is_pre & dec_ok & (dec_mode == INDEX_PLAIN_MODE);
    wire        ea_go     = (st == ST_ARG2) | ((st == ST_ARG1) & ~two_arg);
    wire [15:0] core_addr = plain_go ? index_pair : ea_go ? ea_calc : pc;
    wire        pc_step   = (st == ST_FETCH) | ((st == ST_DEC) & (is_pre | (dec_ok & ~plain_go)))
                            | ((st == ST_ARG1) & two_arg);
    wire        access    = (st == ST_FETCH) | (st == ST_DEC) | (st == ST_ARG1) | (st == ST_ARG2);
    // signed displacement from the next address
    wire [15:0] brnch_sum = pc + {{8{wb_dat_i[7]}}, wb_dat_i[7:0]};

    wire [MEM_AW-1:0] mem_addr = busy_o ? core_addr[MEM_AW-1:0] : wb_adr_i[MEM_AW+1:2];
    wire              mem_we   = mem_go & wb_we_i & wb_sel_i[0];

    awc_mem #(
        .AW (MEM_AW),
        .DW (8)
    ) u_mem (
        .clk_i   (clk_i),
        .we_i    (mem_we),
        .addr_i  (mem_addr),
        .wdata_i (wb_dat_i[7:0]),
        .rdata_o (mem_q)
    );

    // operands are the accumulator and carry held before the write-back
    awc_alu u_alu (
        .acc_i     (acc),
        .operand_i (mem_q),
        .carry_i   (flags.c),
        .out_o     (alu_out)
    );

    always_comb begin
        next_st = st;
        unique case (st)
            ST_IDLE:  if (start) next_st = ST_FETCH;
            ST_FETCH: next_st = ST_DEC;
            ST_DEC: begin
                if (is_pre) next_st = ST_DEC;
                else if (!dec_ok) next_st = ST_IDLE;
                else if (dec_short) next_st = ST_EXEC;
                else next_st = ST_ARG1;
            end
            ST_ARG1:  next_st = two_arg ? ST_ARG2 : ST_EXEC;
            ST_ARG2:  next_st = ST_EXEC;
            ST_EXEC:  next_st = ST_IDLE;
            default:  next_st = ST_IDLE;
        endcase
    end

    logic [31:0] rd_word;
    assign rd_word = (wb_adr_i == `AWC_ADR_CTRL)   ? {20'h0, last_cycles, 5'h0, done_sticky,
                                                       illegal, busy_o}
                   : (wb_adr_i == `AWC_ADR_ACC)    ? {24'h0, acc}
                   : (wb_adr_i == `AWC_ADR_FLAGS)  ? {24'h0, flags}
                   : (wb_adr_i == `AWC_ADR_INDEX)  ? {16'h0, index_pair}
                   : (wb_adr_i == `AWC_ADR_STACK)  ? {16'h0, stack_ptr}
                   : (wb_adr_i == `AWC_ADR_PC)     ? {16'h0, pc}
                   : (wb_adr_i == `AWC_ADR_BRANCH) ? {16'h0, branch_tgt}
                   : (wb_adr_i == `AWC_ADR_EA)     ? {16'h0, last_ea}
                   : 32'h0;

    // bus answer: registers one cycle, memory two
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            mem_pend <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= (wb_req & ~mem_sel) | mem_pend;
            mem_pend <= mem_go;
            wb_dat_o <= mem_pend ? {24'h0, mem_q} : rd_word;
        end
    end

    // sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st          <= ST_IDLE;
            busy_o      <= 1'b0;
            done_o      <= 1'b0;
            mode        <= LITERAL_OPERAND_MODE;
            prefixed    <= 1'b0;
            wide_high   <= 8'h00;
            cyc_cnt     <= 4'h0;
            last_cycles <= 4'h0;
            last_ea     <= 16'h0000;
            illegal     <= 1'b0;
            done_sticky <= 1'b0;
        end else begin
            st       <= next_st;
            busy_o   <= next_st != ST_IDLE;
            done_o   <= st == ST_EXEC;
            prefixed <= (st == ST_DEC) & is_pre;
            if ((st == ST_DEC) && !is_pre) mode <= dec_mode;
            if (st == ST_ARG1) wide_high <= mem_q;
            if (start) cyc_cnt <= 4'h0;
            else if (access) cyc_cnt <= cyc_cnt + 4'h1;
            if (access && st != ST_FETCH) last_ea <= core_addr;
            if (st == ST_EXEC) last_cycles <= cyc_cnt;
            illegal     <= ~start & (illegal | ((st == ST_DEC) & ~is_pre & ~dec_ok));
            done_sticky <= ~start & (done_sticky | (st == ST_EXEC));
        end
    end

    // programmer-visible registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc        <= `AWC_ACC_RST;
            flags      <= `AWC_FLAGS_RST;
            index_pair <= `AWC_INDEX_RST;
            stack_ptr  <= `AWC_STACK_RST;
            pc         <= `AWC_PC_RST;
            branch_tgt <= `AWC_PC_RST;
        end else begin
            if (st == ST_EXEC) begin
                // result and the V, H, N, Z, C flags written together; I is kept
                acc     <= alu_out.res;
                flags.v <= alu_out.v;
                flags.h <= alu_out.h;
                flags.n <= alu_out.n;
                flags.z <= alu_out.z;
                flags.c <= alu_out.c;
            end else if (wr_flags) begin
                // fixed layout, bits six and five stay one
                flags <= '{v: wb_dat_i[`AWC_FLAG_V], one6: 1'b1, one5: 1'b1,
                           h: wb_dat_i[`AWC_FLAG_H], i: wb_dat_i[`AWC_FLAG_I],
                           n: wb_dat_i[`AWC_FLAG_N], z: wb_dat_i[`AWC_FLAG_Z],
                           c: wb_dat_i[`AWC_FLAG_C]};
            end
            if (wr_acc) acc <= wb_dat_i[7:0];
            if (wr_index) index_pair <= lane16(index_pair, wb_dat_i, wb_sel_i);
            if (wr_stack) stack_ptr <= lane16(stack_ptr, wb_dat_i, wb_sel_i);
            if (wr_pc) pc <= lane16(pc, wb_dat_i, wb_sel_i);
            else if (pc_step) pc <= pc + 16'h0001;
            if (wr_brnch) branch_tgt <= brnch_sum;
        end
    end

    // checking helpers
    function automatic logic [3:0] cycles_for(input awc_mode_e m);
        unique case (m)
            LITERAL_OPERAND_MODE:  cycles_for = `AWC_CYC_LIT;
            DIRECT_PAGE_MODE:      cycles_for = `AWC_CYC_DIRECT;
            LONG_ABSOLUTE_MODE:    cycles_for = `AWC_CYC_LONG_ABS;
            INDEX_LONG_DISP_MODE:  cycles_for = `AWC_CYC_IDX_LONG;
            INDEX_SHORT_DISP_MODE: cycles_for = `AWC_CYC_IDX_SHRT;
            INDEX_PLAIN_MODE:      cycles_for = `AWC_CYC_IDX_PLN;
            STACK_LONG_DISP_MODE:  cycles_for = `AWC_CYC_STK_LONG;
            STACK_SHORT_DISP_MODE: cycles_for = `AWC_CYC_STK_SHRT;
        endcase
    endfunction

    wire [8:0] chk_sum  = {1'b0, acc} + {1'b0, mem_q} + {8'h00, flags.c};
    wire [4:0] chk_half = {1'b0, acc[3:0]} + {1'b0, mem_q[3:0]} + {4'h0, flags.c};

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_acc_sum: assert property (st == ST_EXEC |=> acc == $past(chk_sum[7:0]))
        else $error("accumulator sum wrong");
    a_carry_out: assert property (st == ST_EXEC |=> flags.c == $past(chk_sum[8]))
        else $error("carry flag wrong");
    a_signed_overflow: assert property (st == ST_EXEC |=>
        flags.v == $past((acc[7] == mem_q[7]) && (chk_sum[7] != acc[7])))
        else $error("overflow flag wrong");
    a_half_carry: assert property (st == ST_EXEC |=> flags.h == $past(chk_half[4]))
        else $error("half carry flag wrong");
    a_result_flags: assert property (st == ST_EXEC |=>
        (flags.n == acc[7]) && (flags.z == (acc == 8'h00)))
        else $error("negative or zero flag wrong");
    a_mask_kept: assert property (st == ST_EXEC |=> $stable(flags.i) && flags.one6
        && flags.one5)
        else $error("interrupt mask or fixed bits disturbed");
    a_cycle_table: assert property (st == ST_EXEC |-> cyc_cnt == cycles_for(mode))
        else $error("instruction cycle count wrong");
    a_direct_page: assert property ((st == ST_ARG1) && (mode == DIRECT_PAGE_MODE)
        |-> core_addr == {8'h00, mem_q})
        else $error("direct page address not in page zero");
    a_branch_target: assert property (wr_brnch |=>
        branch_tgt == $past(pc) + {{8{$past(wb_dat_i[7])}}, $past(wb_dat_i[7:0])})
        else $error("branch target wrong");
    a_foreign_opcode: assert property ((st == ST_DEC) && !is_pre && !dec_ok
        |=> (st == ST_IDLE) && illegal)
        else $error("foreign opcode not refused");

    c_stack_long: cover property ((st == ST_EXEC) && (mode == STACK_LONG_DISP_MODE));
    c_index_plain: cover property ((st == ST_EXEC) && (mode == INDEX_PLAIN_MODE));
    c_refused: cover property ($rose(illegal));
    c_mem_read: cover property (mem_pend && !wb_we_i ##1 wb_ack_o);
endmodule
`default_nettype wire

/* File: hw/awc_alu.sv */
// eight-bit adder with carry in and its flag results
`timescale 1ns/100ps
`default_nettype none
module awc_alu import awc_pkg::*; (
    input  wire logic [7:0] acc_i,
    input  wire logic [7:0] operand_i,
    input  wire logic       carry_i,
    output var  awc_alu_s   out_o
);
    logic [4:0] low_sum;
    logic [8:0] full_sum;
    logic       ovf;

    assign low_sum  = {1'b0, acc_i[3:0]} + {1'b0, operand_i[3:0]} + {4'h0, carry_i};
    assign full_sum = {1'b0, acc_i} + {1'b0, operand_i} + {8'h00, carry_i};
    assign ovf      = (acc_i[7] == operand_i[7]) && (full_sum[7] != acc_i[7]);
    assign out_o    = {full_sum[7:0], ovf, low_sum[4], full_sum[7],
                       full_sum[7:0] == 8'h00, full_sum[8]};
endmodule
`default_nettype wire

/* File: hw/awc_mem.sv */
// byte memory for program and data with registered read port
`timescale 1ns/100ps
`default_nettype none
module awc_mem #(
    parameter int AW = 8,
    parameter int DW = 8
) (
    input  wire logic          clk_i,
    input  wire logic          we_i,
    input  wire logic [AW-1:0] addr_i,
    input  wire logic [DW-1:0] wdata_i,
    output logic      [DW-1:0] rdata_o
);
    logic [DW-1:0] cells [2**AW];

    // read during write returns the old byte
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            cells[addr_i] <= wdata_i;
        end
        rdata_o <= cells[addr_i];
    end
endmodule
`default_nettype wire

/* File: include/awc_map.svh */
// register offsets, field positions, reset values, opcodes and cycle counts
`ifndef AWC_MAP_SVH
`define AWC_MAP_SVH

`define AWC_ADR_CTRL    12'h000
`define AWC_ADR_ACC     12'h004
`define AWC_ADR_FLAGS   12'h008
`define AWC_ADR_INDEX   12'h00c
`define AWC_ADR_STACK   12'h010
`define AWC_ADR_PC      12'h014
`define AWC_ADR_BRANCH  12'h018
`define AWC_ADR_EA      12'h01c
`define AWC_MEM_BIT     11

`define AWC_CTRL_START  0
`define AWC_FLAG_V      7
`define AWC_FLAG_H      4
`define AWC_FLAG_I      3
`define AWC_FLAG_N      2
`define AWC_FLAG_Z      1
`define AWC_FLAG_C      0

`define AWC_FLAGS_RST   8'h60
`define AWC_ACC_RST     8'h00
`define AWC_INDEX_RST   16'h0000
`define AWC_STACK_RST   16'h00ff
`define AWC_PC_RST      16'h0000

`define AWC_OP_PREFIX   8'h9e
`define AWC_OP_LIT      8'ha9
`define AWC_OP_DIRECT   8'hb9
`define AWC_OP_LONG_ABS 8'hc9
`define AWC_OP_IDX_LONG 8'hd9
`define AWC_OP_IDX_SHRT 8'he9
`define AWC_OP_IDX_PLN  8'hf9
`define AWC_OP_STK_LONG 8'hd9
`define AWC_OP_STK_SHRT 8'he9

`define AWC_CYC_LIT      4'h2
`define AWC_CYC_DIRECT   4'h3
`define AWC_CYC_LONG_ABS 4'h4
`define AWC_CYC_IDX_LONG 4'h4
`define AWC_CYC_IDX_SHRT 4'h3
`define AWC_CYC_IDX_PLN  4'h2
`define AWC_CYC_STK_LONG 4'h5
`define AWC_CYC_STK_SHRT 4'h4

`endif

/* File: include/awc_pkg.sv */
// types shared by the add-with-carry datapath
package awc_pkg;

    typedef enum logic [5:0] {
        ST_IDLE  = 6'h01,
        ST_FETCH = 6'h02,
        ST_DEC   = 6'h04,
        ST_ARG1  = 6'h08,
        ST_ARG2  = 6'h10,
        ST_EXEC  = 6'h20
    } awc_state_e;

    typedef enum logic [2:0] {
        LITERAL_OPERAND_MODE  = 3'h0,
        DIRECT_PAGE_MODE      = 3'h1,
        LONG_ABSOLUTE_MODE    = 3'h2,
        INDEX_LONG_DISP_MODE  = 3'h3,
        INDEX_SHORT_DISP_MODE = 3'h4,
        INDEX_PLAIN_MODE      = 3'h5,
        STACK_LONG_DISP_MODE  = 3'h6,
        STACK_SHORT_DISP_MODE = 3'h7
    } awc_mode_e;

    typedef struct packed {
        logic v;
        logic one6;
        logic one5;
        logic h;
        logic i;
        logic n;
        logic z;
        logic c;
    } awc_flags_s;

    typedef struct packed {
        logic [7:0] res;
        logic       v;
        logic       h;
        logic       n;
        logic       z;
        logic       c;
    } awc_alu_s;

endpackage

/* File: verification/awc_img_model.sv */
// program and data memory image kept beside the bench, loaded into the core over the bus
`timescale 1ns/100ps
`default_nettype none
module awc_img_model;
    logic [7:0] img [256];
    initial begin
        for (int k = 0; k < 256; k++) begin
            img[k] = 8'h00;
        end
    end
    task automatic put16(input logic [7:0] a, input logic [15:0] v);
        img[a] = v[15:8];
        img[a + 8'h01] = v[7:0];
    endtask
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
// self-checking bench for the add-with-carry datapath
`timescale 1ns/100ps
`default_nettype none
`include "awc_map.svh"
module tb_top;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc   = 1'b0;
    logic        stb   = 1'b0;
    logic        we    = 1'b0;
    logic [11:0] adr   = 12'h000;
    logic [3:0]  sel   = 4'h0;
    logic [31:0] wdat  = 32'h0;
    logic [31:0] rdat;
    logic        ack;
    logic        busy;
    logic        done;
    int          fails = 0;
    int          check_count = 0;
    localparam logic [7:0]  OPC [8] = '{`AWC_OP_LIT, `AWC_OP_DIRECT, `AWC_OP_LONG_ABS,
        `AWC_OP_IDX_LONG, `AWC_OP_IDX_SHRT, `AWC_OP_IDX_PLN, `AWC_OP_STK_LONG, `AWC_OP_STK_SHRT};
    localparam logic [3:0]  CYC [8] = '{`AWC_CYC_LIT, `AWC_CYC_DIRECT, `AWC_CYC_LONG_ABS,
        `AWC_CYC_IDX_LONG, `AWC_CYC_IDX_SHRT, `AWC_CYC_IDX_PLN, `AWC_CYC_STK_LONG,
        `AWC_CYC_STK_SHRT};
    localparam logic [7:0]  LEN [8] = '{8'h02, 8'h02, 8'h03, 8'h03, 8'h02, 8'h01, 8'h04, 8'h03};
    localparam logic [7:0]  AV  [8] = '{8'h7f, 8'hff, 8'h80, 8'h0f, 8'h3c, 8'h50, 8'h01, 8'hf0};
    localparam logic [7:0]  MV  [8] = '{8'h01, 8'h00, 8'h80, 8'h00, 8'h42, 8'h50, 8'hfe, 8'hf0};
    localparam logic [7:0]  FV  [8] = '{8'h00, 8'h01, 8'h00, 8'h09, 8'h00, 8'h08, 8'h01, 8'h09};
    localparam logic [15:0] BAS [8] = '{16'h0, 16'h0, 16'h0, 16'h0100, 16'h0030, 16'h0060,
        16'h0200, 16'h0200};
    localparam logic [15:0] DSP [8] = '{16'h0, 16'h0, 16'h0, 16'hff80, 16'h00f0, 16'h0,
        16'h0010, 16'h0030};
    localparam logic [15:0] EA  [8] = '{16'h0, 16'h0040, 16'h1250, 16'h0080, 16'h0120,
        16'h0060, 16'h0210, 16'h0230};

    always #5 clk_i = ~clk_i;

    awc_adc_core #(.MEM_AW(8)) dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .busy_o(busy), .done_o(done));
    awc_img_model img_u ();

    task automatic stop_test();
        if (fails == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one classic cycle, held until ack is sampled high
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 40);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1) begin
            fails++;
            stop_test();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(nm, e, q);
    endtask

    task automatic put(input logic [7:0] n);
        wr(12'h800 + {2'b00, n, 2'b00}, {24'h0, img_u.img[n]});
    endtask

    function automatic logic [15:0] adc_ref(input logic [7:0] a, input logic [7:0] m,
                                            input logic [7:0] f);
        logic [7:0] r;
        logic       v;
        logic       h;
        logic       c;
        r = a + m + {7'h0, f[0]};
        v = (a[7] & m[7] & ~r[7]) | (~a[7] & ~m[7] & r[7]);
        h = (a[3] & m[3]) | (m[3] & ~r[3]) | (~r[3] & a[3]);
        c = (a[7] & m[7]) | (m[7] & ~r[7]) | (~r[7] & a[7]);
        return {v, 2'b11, h, f[3], r[7], r == 8'h00, c, r};
    endfunction

    initial begin
        logic [31:0] q;
        logic [15:0] e;
        logic [7:0]  p;
        logic        sb;
        int          n;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(`AWC_ADR_FLAGS, 32'h60, "flags reset");
        rd(`AWC_ADR_STACK, 32'h00ff, "stack reset");
        wr(12'h020, 32'h5a);
        rd(12'h020, 32'h0, "unmapped");
        wr(`AWC_ADR_FLAGS, 32'h00);
        rd(`AWC_ADR_FLAGS, 32'h60, "flags fixed ones");
        wr(`AWC_ADR_FLAGS, 32'hff);
        rd(`AWC_ADR_FLAGS, 32'hff, "flags all");
        wr(`AWC_ADR_PC, 32'h0100);
        wr(`AWC_ADR_BRANCH, 32'h80);
        rd(`AWC_ADR_BRANCH, 32'h0080, "branch back");
        wr(`AWC_ADR_BRANCH, 32'h7f);
        rd(`AWC_ADR_BRANCH, 32'h017f, "branch forward");
        for (int i = 0; i < 8; i++) begin
            p = (i >= 6) ? 8'h01 : 8'h00;
            img_u.img[0] = `AWC_OP_PREFIX;
            img_u.img[p] = OPC[i];
            if (i == 0) img_u.img[1] = MV[i];
            else if (i == 2) img_u.put16(p + 8'h01, EA[i]);
            else if (i == 3 || i == 6) img_u.put16(p + 8'h01, DSP[i]);
            else img_u.img[p + 8'h01] = (i == 1) ? EA[i][7:0] : DSP[i][7:0];
            if (i != 0) img_u.img[EA[i][7:0]] = MV[i];
            for (int j = 0; j < 4; j++) put(j[7:0]);
            if (i != 0) put(EA[i][7:0]);
            wr(`AWC_ADR_ACC, {24'h0, AV[i]});
            wr(`AWC_ADR_FLAGS, {24'h0, FV[i]});
            wr(`AWC_ADR_INDEX, {16'h0, (i >= 6) ? 16'h0f00 : BAS[i]});
            wr(`AWC_ADR_STACK, {16'h0, (i >= 6) ? BAS[i] : 16'h0f00});
            wr(`AWC_ADR_PC, 32'h0);
            wr(`AWC_ADR_CTRL, 32'h1);
            if (i == 6) wr(`AWC_ADR_ACC, 32'h0);
            wait_done(sb);
            chk("busy seen", 32'h1, {31'h0, sb});
            e = adc_ref(AV[i], MV[i], FV[i]);
            rd(`AWC_ADR_ACC, {24'h0, e[7:0]}, "accumulator");
            rd(`AWC_ADR_FLAGS, {24'h0, e[15:8]}, "flags");
            bus(1'b0, `AWC_ADR_CTRL, 32'h0, q);
            chk("cycles", {CYC[i], 3'b100}, {q[11:8], q[2:0]});
            if (i != 0)
                rd(`AWC_ADR_EA, {16'h0, EA[i]}, "address");
            rd(`AWC_ADR_PC, {24'h0, LEN[i]}, "next pc");
        end
        rd(12'h800 + {2'b00, EA[2][7:0], 2'b00}, {24'h0, MV[2]}, "memory byte");
        img_u.img[0] = `AWC_OP_PREFIX;
        img_u.img[1] = `AWC_OP_IDX_PLN;
        put(8'h00);
        put(8'h01);
        wr(`AWC_ADR_ACC, 32'h55);
        wr(`AWC_ADR_FLAGS, 32'h01);
        wr(`AWC_ADR_PC, 32'h0);
        wr(`AWC_ADR_CTRL, 32'h1);
        n = 0;
        do begin
            bus(1'b0, `AWC_ADR_CTRL, 32'h0, q);
            n++;
        end while (q[1] !== 1'b1 && n < 30);
        chk("refused status", 32'h2, {29'h0, q[2:0]});
        rd(`AWC_ADR_ACC, 32'h55, "refused acc");
        rd(`AWC_ADR_FLAGS, 32'h61, "refused flags");
        rd(`AWC_ADR_PC, 32'h0002, "refused pc");
        stop_test();
    end

    task automatic wait_done(output logic sb);
        int n;
        sb = 1'b0;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
            if (busy === 1'b1) sb = 1'b1;
        end while (done !== 1'b1 && n < 60);
        if (done !== 1'b1) begin
            fails++;
            stop_test();
        end
    endtask
endmodule
`default_nettype wire
